/* shared/cfg_ctrl_pkg.sv */
// Shared constants and carrier types for the configuration control block
package cfg_ctrl_pkg;

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int DIV_W = 4;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFS_CONFIG    = 8'h00;
    localparam logic [ADR_W-1:0] OFS_UNLOCK    = 8'h04;
    localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h08;
    localparam logic [ADR_W-1:0] OFS_TRACE_DIV = 8'h0c;

    // configuration_control field positions
    localparam int BIT_PIN_LOCK = 13;
    localparam int BIT_MOD_LOCK = 12;
    localparam int BIT_DEBUG_EN = 3;
    localparam int BIT_TRACE_EN = 2;
    localparam int BIT_TDO_SEL  = 0;

    // Byte lanes holding the fields
    localparam int LANE_LOW  = 0;
    localparam int LANE_HIGH = 1;

    // Reset values
    localparam logic PIN_LOCK_RST = 1'b0;
    localparam logic MOD_LOCK_RST = 1'b0;
    localparam logic DEBUG_EN_RST = 1'b0;
    localparam logic TRACE_EN_RST = 1'b0;
    localparam logic TDO_SEL_RST  = 1'b1;
    localparam logic [DIV_W-1:0] TRACE_DIV_RST = 4'h1;

    // Status register fields
    localparam int STAT_UNLOCKED   = 0;
    localparam int STAT_PIN_REJECT = 1;
    localparam int STAT_MOD_REJECT = 2;
    localparam int STAT_STRAP_DONE = 3;

    // Unlock keys, values arbitrary
    localparam logic [DAT_W-1:0] UNLOCK_KEY_1 = 32'h5a5a_0f0f;
    localparam logic [DAT_W-1:0] UNLOCK_KEY_2 = 32'ha5a5_f0f0;

    // Edges after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    localparam int GUARD_PIN = 0;
    localparam int GUARD_MOD = 1;
    localparam int GUARD_N   = 2;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic             ack;
        logic [DAT_W-1:0] dat;
    } wb_rsp_t;

    // Write request toward a protected register group
    typedef struct packed {
        logic             valid;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } prot_wr_t;

endpackage

/* verilog/cfg_unlock_detector.sv */
// Unlock key sequence detector for the lock fields
`timescale 1ns/100ps
`default_nettype none
module cfg_unlock_detector (
    input  wire logic                               clk_sys_i,
    input  wire logic                               rstn_i,
    input  wire logic                               key_wr_i,
    input  wire logic [cfg_ctrl_pkg::DAT_W-1:0]     key_i,
    output logic                                    unlocked_o
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_OPEN} key_state_t;

    key_state_t state;

    // Two keys in a row open; any other key write closes again
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= KEY_IDLE;
        end else if (key_wr_i) begin
            if (key_i == cfg_ctrl_pkg::UNLOCK_KEY_1) begin
                state <= KEY_FIRST;
            end else if (state == KEY_FIRST &&
                         key_i == cfg_ctrl_pkg::UNLOCK_KEY_2) begin
                state <= KEY_OPEN;
            end else begin
                state <= KEY_IDLE;
            end
        end
    end

    assign unlocked_o = (state == KEY_OPEN);
endmodule // cfg_unlock_detector
`default_nettype wire

/* verilog/cfg_write_guard.sv */
// Gate for writes to one protected register group
`timescale 1ns/100ps
`default_nettype none
module cfg_write_guard (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rstn_i,
    input  wire logic                   lock_i,
    input  wire cfg_ctrl_pkg::prot_wr_t req_i,
    output cfg_ctrl_pkg::prot_wr_t      grant_o,
    output logic                        reject_o
);
    // Pass the write one cycle later, or drop it and pulse reject
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            grant_o <= '0;
        end else begin
            grant_o.valid <= req_i.valid && !lock_i;
            grant_o.adr   <= req_i.adr;
            grant_o.dat   <= req_i.dat;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reject_o <= 1'b0;
        end else begin
            reject_o <= req_i.valid && lock_i;
        end
    end
endmodule // cfg_write_guard
`default_nettype wire

/* verilog/cfg_ctrl.sv */
// Configuration control register block on a classic Wishbone slave
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module cfg_ctrl (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rstn_i,
    input  wire cfg_ctrl_pkg::wb_req_t      wb_i,
    output cfg_ctrl_pkg::wb_rsp_t           wb_o,
    input  wire logic                       debug_en_strap_i,
    input  wire cfg_ctrl_pkg::prot_wr_t     pin_select_wr_i,
    input  wire cfg_ctrl_pkg::prot_wr_t     module_disable_wr_i,
    output cfg_ctrl_pkg::prot_wr_t          pin_select_wr_o,
    output cfg_ctrl_pkg::prot_wr_t          module_disable_wr_o,
    output logic                            debug_port_enable_o,
    output logic                            two_wire_data_out_select_o,
    input  wire logic [7:0]                 trace_data_i,
    output logic [7:0]                      trace_data_o,
    output logic                            trace_data_oe_o,
    output logic                            trace_clk_o
);

    function automatic logic hit(input logic [cfg_ctrl_pkg::ADR_W-1:0] a,
                                 input logic [cfg_ctrl_pkg::ADR_W-1:0] o);
        hit = (a == o);
    endfunction

    // Register fields
    logic                          pin_select_lock;
    logic                          module_disable_lock;
    logic                          debug_port_enable;
    logic                          trace_output_enable;
    logic                          two_wire_data_out_select;
    logic [cfg_ctrl_pkg::DIV_W-1:0] trace_div;

    // Sticky reject flags
    logic pin_reject_flag;
    logic mod_reject_flag;

    // Bus strobes
    logic access;
    logic wr_fire;
    logic low_lane;
    logic high_lane;
    logic key_wr;
    logic unlocked;

    // Strap capture
    logic       strap_meta;
    logic       strap_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic       strap_load;

    // Guards
    cfg_ctrl_pkg::prot_wr_t guard_req   [cfg_ctrl_pkg::GUARD_N];
    cfg_ctrl_pkg::prot_wr_t guard_grant [cfg_ctrl_pkg::GUARD_N];
    logic                   guard_lock  [cfg_ctrl_pkg::GUARD_N];
    logic                   guard_rej   [cfg_ctrl_pkg::GUARD_N];

    // Trace clock divider
    logic [cfg_ctrl_pkg::DIV_W-1:0] trace_cnt;

    logic [cfg_ctrl_pkg::DAT_W-1:0] next_rdata;

    // Response flops, packed onto the bus port
    logic                           bus_ack;
    logic [cfg_ctrl_pkg::DAT_W-1:0] bus_rdata;

    assign access    = wb_i.cyc && wb_i.stb && !bus_ack;
    assign wr_fire   = access && wb_i.we;
    assign low_lane  = wb_i.sel[cfg_ctrl_pkg::LANE_LOW];
    assign high_lane = wb_i.sel[cfg_ctrl_pkg::LANE_HIGH];
    assign key_wr    = wr_fire && hit(wb_i.adr, cfg_ctrl_pkg::OFS_UNLOCK)
                       && (&wb_i.sel);

    cfg_unlock_detector u_unlock (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .key_wr_i   (key_wr),
        .key_i      (wb_i.dat),
        .unlocked_o (unlocked)
    );

    // Classic single-cycle slave: ack one edge after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= access;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        next_rdata = '0;
        if (hit(wb_i.adr, cfg_ctrl_pkg::OFS_CONFIG)) begin
            next_rdata[cfg_ctrl_pkg::BIT_PIN_LOCK] = pin_select_lock;
            next_rdata[cfg_ctrl_pkg::BIT_MOD_LOCK] = module_disable_lock;
            next_rdata[cfg_ctrl_pkg::BIT_DEBUG_EN] = debug_port_enable;
            next_rdata[cfg_ctrl_pkg::BIT_TRACE_EN] = trace_output_enable;
            next_rdata[cfg_ctrl_pkg::BIT_TDO_SEL]  = two_wire_data_out_select;
            // Remaining bits stay zero
        end else if (hit(wb_i.adr, cfg_ctrl_pkg::OFS_STATUS)) begin
            next_rdata[cfg_ctrl_pkg::STAT_UNLOCKED]   = unlocked;
            next_rdata[cfg_ctrl_pkg::STAT_PIN_REJECT] = pin_reject_flag;
            next_rdata[cfg_ctrl_pkg::STAT_MOD_REJECT] = mod_reject_flag;
            next_rdata[cfg_ctrl_pkg::STAT_STRAP_DONE] = strap_done;
        end else if (hit(wb_i.adr, cfg_ctrl_pkg::OFS_TRACE_DIV)) begin
            next_rdata[cfg_ctrl_pkg::DIV_W-1:0] = trace_div;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_rdata <= '0;
        end else if (access && !wb_i.we) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= '0;
        end
    end

    assign wb_o = '{ack: bus_ack, dat: bus_rdata};

    // Strap: two flip-flops, then loaded once after reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            strap_meta <= debug_en_strap_i;
            strap_sync <= strap_meta;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_cnt  <= '0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            if (strap_cnt == cfg_ctrl_pkg::STRAP_SETTLE) begin
                strap_done <= 1'b1;
            end else begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    assign strap_load = !strap_done &&
                        (strap_cnt == cfg_ctrl_pkg::STRAP_SETTLE);

    // Lock fields: change only while the key sequence is open
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_select_lock     <= cfg_ctrl_pkg::PIN_LOCK_RST;
            module_disable_lock <= cfg_ctrl_pkg::MOD_LOCK_RST;
        end else if (wr_fire && high_lane && unlocked &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_CONFIG)) begin
            pin_select_lock     <= wb_i.dat[cfg_ctrl_pkg::BIT_PIN_LOCK];
            module_disable_lock <= wb_i.dat[cfg_ctrl_pkg::BIT_MOD_LOCK];
        end
    end

    // Debug port enable: strap value wins in its load cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            debug_port_enable <= cfg_ctrl_pkg::DEBUG_EN_RST;
        end else if (strap_load) begin
            debug_port_enable <= strap_sync;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_CONFIG)) begin
            debug_port_enable <= wb_i.dat[cfg_ctrl_pkg::BIT_DEBUG_EN];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trace_output_enable <= cfg_ctrl_pkg::TRACE_EN_RST;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_CONFIG)) begin
            trace_output_enable <= wb_i.dat[cfg_ctrl_pkg::BIT_TRACE_EN];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            two_wire_data_out_select <= cfg_ctrl_pkg::TDO_SEL_RST;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_CONFIG)) begin
            two_wire_data_out_select <= wb_i.dat[cfg_ctrl_pkg::BIT_TDO_SEL];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trace_div <= cfg_ctrl_pkg::TRACE_DIV_RST;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_TRACE_DIV)) begin
            trace_div <= wb_i.dat[cfg_ctrl_pkg::DIV_W-1:0];
        end
    end

    // Write guards for the two protected register groups
    assign guard_req[cfg_ctrl_pkg::GUARD_PIN]  = pin_select_wr_i;
    assign guard_req[cfg_ctrl_pkg::GUARD_MOD]  = module_disable_wr_i;
    assign guard_lock[cfg_ctrl_pkg::GUARD_PIN] = pin_select_lock;
    assign guard_lock[cfg_ctrl_pkg::GUARD_MOD] = module_disable_lock;

    genvar g;
    generate
        for (g = 0; g < cfg_ctrl_pkg::GUARD_N; g = g + 1) begin : g_guard
            cfg_write_guard u_guard (
                .clk_sys_i (clk_sys_i),
                .rstn_i    (rstn_i),
                .lock_i    (guard_lock[g]),
                .req_i     (guard_req[g]),
                .grant_o   (guard_grant[g]),
                .reject_o  (guard_rej[g])
            );
        end
    endgenerate

    assign pin_select_wr_o     = guard_grant[cfg_ctrl_pkg::GUARD_PIN];
    assign module_disable_wr_o = guard_grant[cfg_ctrl_pkg::GUARD_MOD];

    // Sticky reject flags, write one to clear; a new reject wins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_reject_flag <= 1'b0;
        end else if (guard_rej[cfg_ctrl_pkg::GUARD_PIN]) begin
            pin_reject_flag <= 1'b1;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_STATUS) &&
                     wb_i.dat[cfg_ctrl_pkg::STAT_PIN_REJECT]) begin
            pin_reject_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mod_reject_flag <= 1'b0;
        end else if (guard_rej[cfg_ctrl_pkg::GUARD_MOD]) begin
            mod_reject_flag <= 1'b1;
        end else if (wr_fire && low_lane &&
                     hit(wb_i.adr, cfg_ctrl_pkg::OFS_STATUS) &&
                     wb_i.dat[cfg_ctrl_pkg::STAT_MOD_REJECT]) begin
            mod_reject_flag <= 1'b0;
        end
    end

    // Debug port controls
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            debug_port_enable_o <= cfg_ctrl_pkg::DEBUG_EN_RST;
        end else begin
            debug_port_enable_o <= debug_port_enable;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            two_wire_data_out_select_o <= cfg_ctrl_pkg::TDO_SEL_RST;
        end else begin
            two_wire_data_out_select_o <= two_wire_data_out_select;
        end
    end

    // Trace clock: toggles every trace_div+1 cycles while enabled
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trace_cnt   <= '0;
            trace_clk_o <= 1'b0;
        end else if (!trace_output_enable) begin
            trace_cnt   <= '0;
            trace_clk_o <= 1'b0;
        end else if (trace_cnt >= trace_div) begin
            trace_cnt   <= '0;
            trace_clk_o <= !trace_clk_o;
        end else begin
            trace_cnt <= trace_cnt + 4'h1;
        end
    end

    // Trace data pins driven only while enabled
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trace_data_o    <= 8'h00;
            trace_data_oe_o <= 1'b0;
        end else begin
            trace_data_o    <= trace_output_enable ? trace_data_i : 8'h00;
            trace_data_oe_o <= trace_output_enable;
        end
    end

endmodule // cfg_ctrl
`default_nettype wire

/* test/cfg_ctrl_chk.sv */
// Port-level assertions for the configuration control block
`timescale 1ns/100ps
`default_nettype none
module cfg_ctrl_chk (
    input wire logic                   clk_sys_i,
    input wire logic                   rstn_i,
    input wire cfg_ctrl_pkg::wb_req_t  wb_i,
    input wire cfg_ctrl_pkg::wb_rsp_t  wb_o,
    input wire logic                   debug_en_strap_i,
    input wire cfg_ctrl_pkg::prot_wr_t pin_select_wr_i,
    input wire cfg_ctrl_pkg::prot_wr_t module_disable_wr_i,
    input wire cfg_ctrl_pkg::prot_wr_t pin_select_wr_o,
    input wire cfg_ctrl_pkg::prot_wr_t module_disable_wr_o,
    input wire logic                   debug_port_enable_o,
    input wire logic                   two_wire_data_out_select_o,
    input wire logic [7:0]             trace_data_i,
    input wire logic [7:0]             trace_data_o,
    input wire logic                   trace_data_oe_o,
    input wire logic                   trace_clk_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    ack_answer_a: assert property (
        wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("bus request not answered in one cycle");
    ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("bus ack longer than one cycle");
    unimpl_zero_a: assert property (wb_o.ack |->
        (wb_o.dat & 32'hffffcff0) == 32'h0 &&
        (wb_i.adr != cfg_ctrl_pkg::OFS_CONFIG || !wb_o.dat[1]))
        else $error("unimplemented bits read nonzero");
    config_readback_a: assert property (
        wb_o.ack && !wb_i.we && wb_i.adr == cfg_ctrl_pkg::OFS_CONFIG |->
        wb_o.dat[3] == debug_port_enable_o && wb_o.dat[2] == trace_data_oe_o
        && wb_o.dat[0] == two_wire_data_out_select_o)
        else $error("readback differs from control outputs");
    reset_out_a: assert property ($rose(rstn_i) |->
        two_wire_data_out_select_o && !debug_port_enable_o && !trace_data_oe_o)
        else $error("outputs wrong after reset");
    strap_load_a: assert property (
        $rose(rstn_i) |-> ##4 debug_port_enable_o == debug_en_strap_i)
        else $error("debug enable did not take the strap");
    pin_pass_a: assert property (pin_select_wr_o.valid |->
        $past(pin_select_wr_i.valid) && pin_select_wr_o.dat ==
        $past(pin_select_wr_i.dat) && pin_select_wr_o.adr ==
        $past(pin_select_wr_i.adr))
        else $error("pin-select write not from a request");
    mod_pass_a: assert property (module_disable_wr_o.valid |->
        $past(module_disable_wr_i.valid) && module_disable_wr_o.dat ==
        $past(module_disable_wr_i.dat) && module_disable_wr_o.adr ==
        $past(module_disable_wr_i.adr))
        else $error("module-disable write not from a request");
    trace_data_a: assert property (trace_data_o ==
        (trace_data_oe_o ? $past(trace_data_i) : 8'h00))
        else $error("trace data wrong for enable state");
    trace_stop_a: assert property (
        !trace_data_oe_o [*3] |-> !trace_clk_o)
        else $error("trace clock running while disabled");

    cover property (wb_o.ack && wb_i.we);
    cover property (pin_select_wr_o.valid);
    cover property (trace_data_oe_o && $rose(trace_clk_o));
endmodule // cfg_ctrl_chk

bind cfg_ctrl cfg_ctrl_chk u_cfg_ctrl_chk (
    .clk_sys_i, .rstn_i, .wb_i, .wb_o, .debug_en_strap_i,
    .pin_select_wr_i, .module_disable_wr_i, .pin_select_wr_o,
    .module_disable_wr_o, .debug_port_enable_o, .two_wire_data_out_select_o,
    .trace_data_i, .trace_data_o, .trace_data_oe_o, .trace_clk_o
);
`default_nettype wire

/* test/cfg_ctrl_test.sv */
// Self-checking bench for the configuration control block
`timescale 1ns/100ps
`default_nettype none
module cfg_ctrl_test;
    logic                   clk_sys_i;
    logic                   rstn_i;
    logic                   strap;
    cfg_ctrl_pkg::wb_req_t  wb_i;
    cfg_ctrl_pkg::wb_rsp_t  wb_o;
    cfg_ctrl_pkg::prot_wr_t pin_i, mod_i, pin_o, mod_o;
    logic                   dbg_o, tdo_o, oe_o, tclk_o;
    logic [7:0]             tdat_i, tdat_o;
    int                     num_errors;
    int                     tests_run;

    cfg_ctrl u_cfg_ctrl (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_i(wb_i), .wb_o(wb_o),
        .debug_en_strap_i(strap), .pin_select_wr_i(pin_i),
        .module_disable_wr_i(mod_i), .pin_select_wr_o(pin_o),
        .module_disable_wr_o(mod_o), .debug_port_enable_o(dbg_o),
        .two_wire_data_out_select_o(tdo_o), .trace_data_i(tdat_i),
        .trace_data_o(tdat_o), .trace_data_oe_o(oe_o), .trace_clk_o(tclk_o)
    );

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic single cycle; waits on ack under a bounded count
    task automatic wb_acc(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat, output logic [31:0] rd);
        int n;
        @(posedge clk_sys_i);
        wb_i <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_o.ack !== 1'b1 && n < 20);
        rd = wb_o.dat;
        wb_i <= '0;
        if (n >= 20) begin
            num_errors++;
            $display("Error bus ack expected 1 seen 0");
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_acc(1'b1, adr, dat, d);
    endtask

    task automatic rd(input string what, input logic [7:0] adr,
                      input logic [31:0] exp);
        logic [31:0] got;
        wb_acc(1'b0, adr, 32'h0, got);
        chk(what, exp, got);
    endtask

    // One protected write pulse toward pin-select (grp 0) or module-disable
    task automatic prot(input logic grp, input logic pass);
        @(posedge clk_sys_i);
        if (grp)
            mod_i <= '{1'b1, 8'h21, 32'h0000_00a5};
        else
            pin_i <= '{1'b1, 8'h12, 32'h0000_005a};
        @(posedge clk_sys_i);
        pin_i <= '0;
        mod_i <= '0;
        #1;
        chk("pin write valid", {31'h0, pass & ~grp}, {31'h0, pin_o.valid});
        chk("mod write valid", {31'h0, pass & grp}, {31'h0, mod_o.valid});
        if (pass && grp)
            chk("mod write", 32'h2100_00a5, {mod_o.adr, mod_o.dat[23:0]});
        if (pass && !grp)
            chk("pin write", 32'h1200_005a, {pin_o.adr, pin_o.dat[23:0]});
    endtask

    task automatic count_clk(input logic [31:0] exp);
        int n;
        logic last;
        repeat (4) @(posedge clk_sys_i);
        #1;
        n = 0;
        last = tclk_o;
        repeat (20) begin
            @(posedge clk_sys_i);
            #1;
            if (tclk_o !== last)
                n++;
            last = tclk_o;
        end
        chk("trace clock toggles", exp, n);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) tdat_i <= tdat_i + 8'h1;

    initial begin
        rstn_i = 1'b0;
        strap = 1'b1;
        wb_i = '0;
        pin_i = '0;
        mod_i = '0;
        tdat_i = 8'h00;
        num_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        chk("reset tdo select", 32'h1, {31'h0, tdo_o});
        chk("reset debug enable", 32'h0, {31'h0, dbg_o});
        @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rd("config after reset", cfg_ctrl_pkg::OFS_CONFIG, 32'h9);
        chk("debug port enable", 32'h1, {31'h0, dbg_o});
        $display("Test reset done");
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'hffff_ffff);
        rd("config all ones", cfg_ctrl_pkg::OFS_CONFIG, 32'hd);
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'h0);
        rd("config zero", cfg_ctrl_pkg::OFS_CONFIG, 32'h0);
        chk("debug port off", 32'h0, {31'h0, dbg_o});
        chk("tdo select off", 32'h0, {31'h0, tdo_o});
        rd("unmapped read", 8'h10, 32'h0);
        rd("key read", cfg_ctrl_pkg::OFS_UNLOCK, 32'h0);
        $display("Test field access done");
        prot(1'b0, 1'b1);
        prot(1'b1, 1'b1);
        wr(cfg_ctrl_pkg::OFS_UNLOCK, cfg_ctrl_pkg::UNLOCK_KEY_1);
        wr(cfg_ctrl_pkg::OFS_UNLOCK, cfg_ctrl_pkg::UNLOCK_KEY_2);
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'h3001);
        rd("locks set", cfg_ctrl_pkg::OFS_CONFIG, 32'h3001);
        wr(cfg_ctrl_pkg::OFS_UNLOCK, 32'h0);
        rd("status relocked", cfg_ctrl_pkg::OFS_STATUS, 32'h8);
        $display("Test unlock done");
        prot(1'b0, 1'b0);
        prot(1'b1, 1'b0);
        rd("status rejects", cfg_ctrl_pkg::OFS_STATUS, 32'he);
        wr(cfg_ctrl_pkg::OFS_STATUS, 32'h6);
        rd("status cleared", cfg_ctrl_pkg::OFS_STATUS, 32'h8);
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'h0001);
        rd("locks held", cfg_ctrl_pkg::OFS_CONFIG, 32'h3001);
        $display("Test lock done");
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'h3005);
        count_clk(32'd10);
        chk("trace enable", 32'h1, {31'h0, oe_o});
        chk("trace data", {24'h0, 8'(tdat_i - 8'h1)}, {24'h0, tdat_o});
        wr(cfg_ctrl_pkg::OFS_TRACE_DIV, 32'h3);
        rd("trace divider", cfg_ctrl_pkg::OFS_TRACE_DIV, 32'h3);
        count_clk(32'd5);
        wr(cfg_ctrl_pkg::OFS_CONFIG, 32'h3001);
        count_clk(32'd0);
        chk("trace clock idle", 32'h0, {31'h0, tclk_o});
        chk("trace disabled", 32'h0, {31'h0, oe_o});
        $display("Test trace done");
        @(posedge clk_sys_i);
        strap <= 1'b0;
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rd("config reset again", cfg_ctrl_pkg::OFS_CONFIG, 32'h1);
        chk("debug strap low", 32'h0, {31'h0, dbg_o});
        $display("Test second reset done");
        summarize();
    end
endmodule // cfg_ctrl_test
`default_nettype wire
